/* File: verilog/rxeq_top.sv */
// Receive equalizer and inversion configuration for eight channels
//
// Overview of operation
// - Each channel keeps its own settings; writing one leaves others alone.
// - Basic mode: 3-bit preset picks one of eight boosts in the group.
// - After reset all eight channels use the FR4 response group.
// - Group choice bit matters only while that channel's override is high.
// - Under override, choice one means FR4 and zero means cable.
// - Bypass bit forces the fixed minimum boost over any preset.
// - Bit 6 of the first boost register selects direct mode.
// - Direct mode applies two 6-bit fields, mid and high boost.
// - Fields are sign-magnitude around zero; bit 5 sets the direction.
// - Each channel has its own P/N inversion control.
// - Reset input is active low; host holds it high to run.
// - Two straps give the low slave address bits, first is LSB.
`timescale 1ns/1ns
`include "rxeq_map.svh"
module rxeq_top
  import rxeq_pkg::*;
#(
  // Upper slave address bits; value is arbitrary
  parameter logic [4:0] ADDR_UPPER = 5'h0a
)
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       cfg_wr_i,
  input  wire logic                       cfg_rd_i,
  input  wire logic [7:0]                 cfg_addr_i,
  input  wire logic [7:0]                 cfg_wdata_i,
  input  wire logic                       slave_addr_strap_lo_i,
  input  wire logic                       slave_addr_strap_hi_i,
  output logic [7:0]                      cfg_rdata_o,
  output logic                            cfg_rvalid_o,
  output logic [6:0]                      slave_addr_o,
  output logic [RXEQ_CHANNELS-1:0]        rx_enable_o,
  output logic [RXEQ_CHANNELS-1:0]        pn_invert_o,
  output rxeq_src_t [RXEQ_CHANNELS-1:0]   boost_src_o,
  output rxeq_preset_t [RXEQ_CHANNELS-1:0] rx_boost_preset_o,
  output rxeq_field_t [RXEQ_CHANNELS-1:0] direct_boost_field_a_o,
  output rxeq_field_t [RXEQ_CHANNELS-1:0] direct_boost_field_b_o,
  output rxeq_level_t [RXEQ_CHANNELS-1:0] boost_level_a_o,
  output rxeq_level_t [RXEQ_CHANNELS-1:0] boost_level_b_o
);

  // Address decode
  logic       bank_hit;
  logic [2:0] chan_sel;
  logic [2:0] sub_sel;
  logic       sub_known;

  assign bank_hit  = (cfg_addr_i[7:6] == `RXEQ_BANK_SEL);
  assign chan_sel  = cfg_addr_i[5:3];
  assign sub_sel   = cfg_addr_i[2:0];
  assign sub_known = (sub_sel == `RXEQ_SUB_CFG) ||
                     (sub_sel == `RXEQ_SUB_EQ1) ||
                     (sub_sel == `RXEQ_SUB_EQ3) ||
                     (sub_sel == `RXEQ_SUB_GRP);

  rxeq_cfg_if ch_if [RXEQ_CHANNELS] ();

  logic [7:0] rd_word [RXEQ_CHANNELS];

  // Sign-magnitude field to a two's-complement level
  function automatic rxeq_level_t to_level(input rxeq_field_t f);
    rxeq_level_t mag;
    mag = rxeq_level_t'({1'b0, f[`RXEQ_FIELD_MAG_MSB:0]});
    return f[`RXEQ_FIELD_SIGN_BIT] ? mag : rxeq_level_t'(-mag);
  endfunction

  genvar g;
  generate
    for (g = 0; g < RXEQ_CHANNELS; g++)
    begin : gen_chan
      logic        sel_hit;
      rxeq_level_t level_a;
      rxeq_level_t level_b;

      // One strobe per channel, never broadcast
      assign sel_hit = bank_hit && (chan_sel == 3'(g));
      assign ch_if[g].wr    = cfg_wr_i && sel_hit;
      assign ch_if[g].sub   = sub_sel;
      assign ch_if[g].wdata = cfg_wdata_i;

      rxeq_chan u_chan
      (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .cfg     (ch_if[g])
      );

      assign rd_word[g] =
        (sub_sel == `RXEQ_SUB_CFG) ? ch_if[g].cfg_q :
        (sub_sel == `RXEQ_SUB_EQ1) ? ch_if[g].eq1_q :
        (sub_sel == `RXEQ_SUB_EQ3) ? ch_if[g].eq3_q :
        (sub_sel == `RXEQ_SUB_GRP) ? ch_if[g].grp_q : 8'h00;

      assign level_a = to_level(ch_if[g].field_a);
      assign level_b = to_level(ch_if[g].field_b);

      // Outputs registered so the analog side sees no decode glitches
      always_ff @(posedge clock_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          rx_enable_o[g]            <= 1'b1;
          pn_invert_o[g]            <= 1'b0;
          boost_src_o[g]            <= RXEQ_SRC_FR4;
          rx_boost_preset_o[g]      <= 3'h0;
          direct_boost_field_a_o[g] <= 6'h00;
          direct_boost_field_b_o[g] <= 6'h00;
          boost_level_a_o[g]        <= 6'h00;
          boost_level_b_o[g]        <= 6'h00;
        end
        else
        begin
          rx_enable_o[g]            <= ch_if[g].rx_en;
          pn_invert_o[g]            <= ch_if[g].pn_inv;
          boost_src_o[g]            <= ch_if[g].src;
          rx_boost_preset_o[g]      <= ch_if[g].preset;
          direct_boost_field_a_o[g] <= ch_if[g].field_a;
          direct_boost_field_b_o[g] <= ch_if[g].field_b;
          boost_level_a_o[g]        <= level_a;
          boost_level_b_o[g]        <= level_b;
        end
      end
    end
  endgenerate

  // Readback of the addressed register; unmapped reads return zero
  logic [7:0] rdata_next;
  logic       rd_hit;

  assign rd_hit     = bank_hit && sub_known;
  assign rdata_next = rd_hit ? rd_word[chan_sel] : 8'h00;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_rdata_o  <= 8'h00;
      cfg_rvalid_o <= 1'b0;
    end
    else
    begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i)
        cfg_rdata_o <= rdata_next;
    end
  end

  // Strap pins come from the board, so they are synchronised
  logic strap_lo;
  logic strap_hi;

  rxeq_sync u_sync_lo
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .pin_i   (slave_addr_strap_lo_i),
    .level_o (strap_lo)
  );

  rxeq_sync u_sync_hi
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .pin_i   (slave_addr_strap_hi_i),
    .level_o (strap_hi)
  );

  // Low bit from the first strap, next bit from the second
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      slave_addr_o <= {ADDR_UPPER, 2'b00};
    else
      slave_addr_o <= {ADDR_UPPER, strap_hi, strap_lo};
  end

endmodule

/* File: common/rxeq_map.svh */
// Address decode, field positions and reset values for the receive config
`ifndef RXEQ_MAP_SVH
`define RXEQ_MAP_SVH

// Bank select on cfg_addr[7:6]; channel on [5:3]; register on [2:0]
`define RXEQ_BANK_SEL        2'h2
`define RXEQ_SUB_CFG         3'h0
`define RXEQ_SUB_EQ1         3'h3
`define RXEQ_SUB_EQ3         3'h4
`define RXEQ_SUB_GRP         3'h5

// Configuration register fields
`define RXEQ_CFG_PNINV_BIT   6
`define RXEQ_CFG_BYPASS_BIT  5
`define RXEQ_CFG_RXEN_BIT    4
`define RXEQ_CFG_PRESET_MSB  2

// Direct boost register fields
`define RXEQ_EQ1_DIRECT_BIT  6
`define RXEQ_FIELD_MSB       5
`define RXEQ_FIELD_SIGN_BIT  5
`define RXEQ_FIELD_MAG_MSB   4

// Response group register fields
`define RXEQ_GRP_OVR_BIT     1
`define RXEQ_GRP_CHOICE_BIT  0

// Reset values
`define RXEQ_CFG_RST         8'h10
`define RXEQ_EQ1_RST         8'h00
`define RXEQ_EQ3_RST         8'h00
`define RXEQ_GRP_RST         8'h00

// Writable bits; everything else reads as zero
`define RXEQ_CFG_MASK        8'h77
`define RXEQ_EQ1_MASK        8'h7f
`define RXEQ_EQ3_MASK        8'h3f
`define RXEQ_GRP_MASK        8'h03

`endif

/* File: common/rxeq_pkg.sv */
// Types shared by the receive equalizer configuration block
package rxeq_pkg;

  localparam int RXEQ_CHANNELS = 8;

  // Which control source drives a channel's equalizer
  typedef enum logic [1:0]
  {
    RXEQ_SRC_FR4,
    RXEQ_SRC_CABLE,
    RXEQ_SRC_BYPASS,
    RXEQ_SRC_DIRECT
  } rxeq_src_t;

  typedef logic [5:0]        rxeq_field_t;
  typedef logic signed [5:0] rxeq_level_t;
  typedef logic [2:0]        rxeq_preset_t;

endpackage

/* File: common/rxeq_cfg_if.sv */
// Write port and decoded controls between the top and one channel
`timescale 1ns/1ns
interface rxeq_cfg_if;
  import rxeq_pkg::*;

  logic         wr;
  logic [2:0]   sub;
  logic [7:0]   wdata;
  logic [7:0]   cfg_q;
  logic [7:0]   eq1_q;
  logic [7:0]   eq3_q;
  logic [7:0]   grp_q;
  rxeq_src_t    src;
  rxeq_preset_t preset;
  rxeq_field_t  field_a;
  rxeq_field_t  field_b;
  logic         pn_inv;
  logic         rx_en;

  modport ctrl (output wr, sub, wdata,
                input  cfg_q, eq1_q, eq3_q, grp_q, src, preset,
                       field_a, field_b, pn_inv, rx_en);
  modport chan (input  wr, sub, wdata,
                output cfg_q, eq1_q, eq3_q, grp_q, src, preset,
                       field_a, field_b, pn_inv, rx_en);
endinterface

/* File: verilog/rxeq_sync.sv */
// Three-stage synchroniser with agreement filter for a strap pin
`timescale 1ns/1ns
module rxeq_sync
(
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Change accepted only once two settled stages agree
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end

  assign level_o = level_reg;

endmodule

/* File: verilog/rxeq_chan.sv */
// Configuration registers and control decode for one receive channel
`timescale 1ns/1ns
`include "rxeq_map.svh"
module rxeq_chan
  import rxeq_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  rxeq_cfg_if.chan  cfg
);

  logic [7:0] cfg_reg;
  logic [7:0] eq1_reg;
  logic [7:0] eq3_reg;
  logic [7:0] grp_reg;
  logic       wr_cfg;
  logic       wr_eq1;
  logic       wr_eq3;
  logic       wr_grp;
  logic       use_fr4;

  // Only this channel's own strobe reaches these registers
  assign wr_cfg = cfg.wr && (cfg.sub == `RXEQ_SUB_CFG);
  assign wr_eq1 = cfg.wr && (cfg.sub == `RXEQ_SUB_EQ1);
  assign wr_eq3 = cfg.wr && (cfg.sub == `RXEQ_SUB_EQ3);
  assign wr_grp = cfg.wr && (cfg.sub == `RXEQ_SUB_GRP);

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_reg <= `RXEQ_CFG_RST;
      eq1_reg <= `RXEQ_EQ1_RST;
      eq3_reg <= `RXEQ_EQ3_RST;
      grp_reg <= `RXEQ_GRP_RST;
    end
    else
    begin
      if (wr_cfg)
        cfg_reg <= cfg.wdata & `RXEQ_CFG_MASK;
      if (wr_eq1)
        eq1_reg <= cfg.wdata & `RXEQ_EQ1_MASK;
      if (wr_eq3)
        eq3_reg <= cfg.wdata & `RXEQ_EQ3_MASK;
      if (wr_grp)
        grp_reg <= cfg.wdata & `RXEQ_GRP_MASK;
    end
  end

  // Choice bit counts only under override, else FR4 default
  assign use_fr4 = grp_reg[`RXEQ_GRP_OVR_BIT] ?
                   grp_reg[`RXEQ_GRP_CHOICE_BIT] : 1'b1;

  // Direct mode outranks bypass, bypass outranks the presets
  assign cfg.src = eq1_reg[`RXEQ_EQ1_DIRECT_BIT] ? RXEQ_SRC_DIRECT :
                   cfg_reg[`RXEQ_CFG_BYPASS_BIT] ? RXEQ_SRC_BYPASS :
                   use_fr4                       ? RXEQ_SRC_FR4 :
                                                   RXEQ_SRC_CABLE;

  assign cfg.preset  = cfg_reg[`RXEQ_CFG_PRESET_MSB:0];
  assign cfg.field_a = eq1_reg[`RXEQ_FIELD_MSB:0];
  assign cfg.field_b = eq3_reg[`RXEQ_FIELD_MSB:0];
  assign cfg.pn_inv  = cfg_reg[`RXEQ_CFG_PNINV_BIT];
  assign cfg.rx_en   = cfg_reg[`RXEQ_CFG_RXEN_BIT];
  assign cfg.cfg_q   = cfg_reg;
  assign cfg.eq1_q   = eq1_reg;
  assign cfg.eq3_q   = eq3_reg;
  assign cfg.grp_q   = grp_reg;

endmodule

/* File: sim/rxeq_assertions.sv */
// Port checker for the receive equalizer configuration top
`timescale 1ns/1ns
module rxeq_assertions
  import rxeq_pkg::*;
#(
  parameter logic [4:0] ADDR_UPPER = 5'h0a
)
(
  input wire logic                            clock_i,
  input wire logic                            rst_b_i,
  input wire logic                            cfg_wr_i,
  input wire logic                            cfg_rd_i,
  input wire logic [7:0]                      cfg_addr_i,
  input wire logic [7:0]                      cfg_wdata_i,
  input wire logic [7:0]                      cfg_rdata_o,
  input wire logic                            cfg_rvalid_o,
  input wire logic [6:0]                      slave_addr_o,
  input wire logic [RXEQ_CHANNELS-1:0]        pn_invert_o,
  input wire rxeq_src_t [RXEQ_CHANNELS-1:0]   boost_src_o,
  input wire rxeq_field_t [RXEQ_CHANNELS-1:0] direct_boost_field_a_o,
  input wire rxeq_level_t [RXEQ_CHANNELS-1:0] boost_level_a_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic       wr_map = cfg_wr_i && cfg_addr_i[7:6] == 2'h2;
  wire logic [2:0] wr_ch  = cfg_addr_i[5:3];
  wire logic [2:0] wr_sub = cfg_addr_i[2:0];

  a_reset_default: assert property ($rose(rst_b_i) |->
    boost_src_o == '0 && pn_invert_o == '0 && direct_boost_field_a_o == '0)
    else $error("defaults missing after reset");
  a_pn_write: assert property (wr_map && wr_sub == 3'h0 |->
    ##2 pn_invert_o[$past(wr_ch, 2)] == $past(cfg_wdata_i[6], 2))
    else $error("inversion does not follow write");
  a_field_write: assert property (wr_map && wr_sub == 3'h3 |->
    ##2 direct_boost_field_a_o[$past(wr_ch, 2)] == $past(cfg_wdata_i[5:0], 2))
    else $error("field a does not follow write");
  a_direct_mode: assert property (wr_map && wr_sub == 3'h3 &&
    cfg_wdata_i[6] |-> ##2 boost_src_o[$past(wr_ch, 2)] == RXEQ_SRC_DIRECT)
    else $error("direct flag ignored");
  a_refused_write: assert property (cfg_wr_i && !wr_map |-> ##2
    $stable(pn_invert_o) && $stable(boost_src_o))
    else $error("foreign write changed a channel");
  a_read_pulse: assert property (cfg_rvalid_o == $past(cfg_rd_i))
    else $error("read valid not one cycle after read");
  a_rdata_hold: assert property (!$past(cfg_rd_i) |->
    $stable(cfg_rdata_o))
    else $error("read data moved without a read");
  a_addr_upper: assert property (slave_addr_o[6:2] == ADDR_UPPER)
    else $error("upper slave address wrong");
  for (genvar c = 0; c < RXEQ_CHANNELS; c++)
  begin : g_lvl
    wire logic [5:0] f = direct_boost_field_a_o[c];
    a_level_sign: assert property (boost_level_a_o[c] ==
      (f[5] ? {1'b0, f[4:0]} : 6'h00 - {1'b0, f[4:0]}))
      else $error("level decode wrong");
  end
  cover property (cfg_rvalid_o);
  cover property (boost_src_o[7] == RXEQ_SRC_CABLE);
  cover property ($rose(rst_b_i));
endmodule

bind rxeq_top rxeq_assertions #(.ADDR_UPPER(ADDR_UPPER)) i_chk
(.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i),
 .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
 .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
 .slave_addr_o(slave_addr_o), .pn_invert_o(pn_invert_o),
 .boost_src_o(boost_src_o), .direct_boost_field_a_o(direct_boost_field_a_o),
 .boost_level_a_o(boost_level_a_o));

/* File: sim/rxeq_host.sv */
// Behavioural configuration host on the register strobes
`timescale 1ns/1ns
module rxeq_host
(
  input  wire logic       clock_i,
  input  wire logic [7:0] cfg_rdata_i,
  input  wire logic       cfg_rvalid_i,
  output logic            cfg_wr_o,
  output logic            cfg_rd_o,
  output logic [7:0]      cfg_addr_o,
  output logic [7:0]      cfg_wdata_o
);
  initial
  begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end
  // One transfer; gap idles first so slow hosts are exercised too
  task automatic xfer(input logic wr, input logic [7:0] a, d, input int gap,
                      output logic [7:0] q, output logic v);
    repeat (gap) @(negedge clock_i);
    @(negedge clock_i);
    cfg_wr_o = wr;
    cfg_rd_o = !wr;
    cfg_addr_o = a;
    cfg_wdata_o = d;
    @(negedge clock_i);
    q = cfg_rdata_i;
    v = cfg_rvalid_i;
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    // Released lines flip so a stale value never looks current
    cfg_addr_o = ~cfg_addr_o;
    cfg_wdata_o = ~cfg_wdata_o;
  endtask
endmodule

/* File: sim/rxeq_top_test.sv */
// Self-checking bench for the receive equalizer configuration top
`timescale 1ns/1ns
`include "rxeq_map.svh"
module rxeq_top_test
  import rxeq_pkg::*;
;
  localparam logic [4:0] UP = 5'h0a;
  logic clock_i, rst_b_i, wr, rd, lo, hi, v;
  logic [7:0] addr, wdata, rdata, q;
  logic rvalid;
  logic [6:0] saddr;
  logic [7:0] en, pn;
  rxeq_src_t [7:0] src;
  rxeq_preset_t [7:0] pre;
  rxeq_field_t [7:0] fa, fb;
  rxeq_level_t [7:0] la, lb;
  logic [7:0] m [8][8];
  int n_errors, samples_checked;

  rxeq_top #(.ADDR_UPPER(UP)) i_dut
  (.clock_i(clock_i), .rst_b_i(rst_b_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
   .cfg_addr_i(addr), .cfg_wdata_i(wdata), .slave_addr_strap_lo_i(lo),
   .slave_addr_strap_hi_i(hi), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
   .slave_addr_o(saddr), .rx_enable_o(en), .pn_invert_o(pn),
   .boost_src_o(src), .rx_boost_preset_o(pre), .direct_boost_field_a_o(fa),
   .direct_boost_field_b_o(fb), .boost_level_a_o(la), .boost_level_b_o(lb));
  rxeq_host i_host
  (.clock_i(clock_i), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid),
   .cfg_wr_o(wr), .cfg_rd_o(rd), .cfg_addr_o(addr), .cfg_wdata_o(wdata));

  always #50 clock_i = ~clock_i;

  function automatic logic [7:0] msk(logic [2:0] s);
    case (s)
      3'h0: return `RXEQ_CFG_MASK;
      3'h3: return `RXEQ_EQ1_MASK;
      3'h4: return `RXEQ_EQ3_MASK;
      3'h5: return `RXEQ_GRP_MASK;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] xsrc(int c);
    if (m[c][3][6]) return 8'h03;
    if (m[c][0][5]) return 8'h02;
    return {7'h00, m[c][5][1] && !m[c][5][0]};
  endfunction
  function automatic logic [7:0] lvl(logic [7:0] f);
    return f[5] ? {3'h0, f[4:0]} : {2'h0, 6'h00 - {1'b0, f[4:0]}};
  endfunction

  task automatic chk(string nm, logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic check_all();
    for (int c = 0; c < 8; c++)
    begin
      chk("pn_invert", {7'h0, pn[c]}, {7'h0, m[c][0][6]});
      chk("rx_enable", {7'h0, en[c]}, {7'h0, m[c][0][4]});
      chk("preset", {5'h0, pre[c]}, {5'h0, m[c][0][2:0]});
      chk("src", {6'h0, src[c]}, xsrc(c));
      chk("field_a", {2'h0, fa[c]}, m[c][3] & 8'h3f);
      chk("field_b", {2'h0, fb[c]}, m[c][4]);
      chk("level_a", {2'h0, la[c]}, lvl(m[c][3]));
      chk("level_b", {2'h0, lb[c]}, lvl(m[c][4]));
    end
  endtask
  task automatic put(int c, logic [2:0] s, logic [7:0] d, int g);
    logic [7:0] a;
    a = 8'h80 + 8'(c * 8) + {5'h0, s};
    i_host.xfer(1'b1, a, d, g, q, v);
    m[c][s] = d & msk(s);
    repeat (2) @(negedge clock_i);
    check_all();
    i_host.xfer(1'b0, a, 8'h00, g, q, v);
    chk("rvalid", {7'h0, v}, 8'h01);
    chk("rdata", q, m[c][s]);
  endtask
  task automatic reset_dut();
    rst_b_i = 1'b0;
    repeat (6) @(negedge clock_i);
    rst_b_i = 1'b1;
    foreach (m[c, s]) m[c][s] = (s == 0) ? `RXEQ_CFG_RST : 8'h00;
    @(negedge clock_i);
    check_all();
  endtask
  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clock_i);
    n_errors++;
    conclude();
  end
  initial
  begin
    clock_i = 1'b0;
    rst_b_i = 1'b0;
    {hi, lo} = 2'($urandom(51));
    reset_dut();
    repeat (6) @(negedge clock_i);
    chk("slave_addr", {1'b0, saddr}, {1'b0, UP, hi, lo});
    for (int i = 0; i < 16; i++)
    begin
      put(7, 3'h3, {1'b0, i[3], 6'h25}, 0);
      put(7, 3'h0, {2'h0, i[2], 5'h13}, 0);
      put(7, 3'h5, {6'h0, i[1:0]}, 0);
    end
    repeat (80) put($urandom % 8, 3'($urandom), 8'($urandom), $urandom % 3);
    // Only the bank bits are foreign; channel and register bits are live
    i_host.xfer(1'b1, 8'h43, 8'hff, 0, q, v);
    i_host.xfer(1'b1, 8'hc0, 8'hff, 0, q, v);
    repeat (2) @(negedge clock_i);
    check_all();
    i_host.xfer(1'b0, 8'hc0, 8'h00, 0, q, v);
    chk("rvalid", {7'h0, v}, 8'h01);
    chk("rdata", q, 8'h00);
    {hi, lo} = ~{hi, lo};
    repeat (8) @(negedge clock_i);
    chk("slave_addr", {1'b0, saddr}, {1'b0, UP, hi, lo});
    reset_dut();
    put(2, 3'h5, 8'h02, 1);
    conclude();
  end
endmodule
